// *** rtl/fsf_consts.vh ***
`ifndef FSF_CONSTS_VH
`define FSF_CONSTS_VH

`define FSF_ADDR_DATA    8'h08
`define FSF_ADDR_MISC    8'h10
`define FSF_ADDR_LEDEN   8'h11
`define FSF_ADDR_HIGHIN  8'h2A
`define FSF_ADDR_SWRST   8'h7D
`define FSF_ADDR_CH_BASE 8'h30
`define FSF_CH_STRIDE    8'h05
`define FSF_CH_SPAN      8'h28

`define FSF_SUB_TON  3'h0
`define FSF_SUB_ONL  3'h1
`define FSF_SUB_OFF  3'h2
`define FSF_SUB_FIN  3'h3
`define FSF_SUB_FOUT 3'h4

`define FSF_MISC_LOG  3
`define FSF_MISC_XRST 2

`define FSF_RST_ZERO  8'h00
`define FSF_RST_ONL   8'hFF
`define FSF_RST_DATA  8'hFF
`define FSF_FADE_MASK 8'hF0

`define FSF_KEY1 8'h12
`define FSF_KEY2 8'h34

`define FSF_CLK_NS    50
`define FSF_TICK_NS   500
`define FSF_TICK_CYC  ((`FSF_TICK_NS) / (`FSF_CLK_NS))
`define FSF_TICK_LAST 8'h09
`define FSF_PWM_LAST  8'hFE
`define FSF_TIME_HI   5'h10

`endif

// *** rtl/fsf_led_engine.v ***
// What this block does
// - On-time field zero gives static mode, on phase held by the IO data bit.
// - On-time 1..15 lasts 64*value PWM periods of 255 ticks, 16..31 uses 512.
// - Linear mode uses the 8-bit on-level register directly, reset all ones.
// - Log mode on fading IOs maps the on level through a nonlinear curve.
// - Off-time field zero gives single-shot mode, off held by the data bit.
// - Off-time 1..15 lasts 64*value PWM periods, 16..31 uses 512.
// - Linear off level is four times the 3-bit off-intensity field.
// - Log mode on fading IOs maps four times the off field the same way.
// - Fade-in 0 is off, else each level step lasts value frames, x16 from 16.
// - Fade-out zero is off, else each step takes value frames, x16 above 15.
// - An 8-bit register holds one high-input-mode bit per IO.
// - Writing 0x12 then 0x34 to the reset key does a full power-on reset.
// - The software reset key always reads zero.
// - Misc bit 3 selects linear (0) or logarithmic (1) mapping.
// - Each IO has an LED enable bit; PWM, blink and fade act only when set.
// - With misc bit 2 set, the external reset only clears the counters.
`timescale 1ns/1ns
`include "fsf_consts.vh"

module fsf_led_engine (
  input  wire       MCLK_I,        // 20 MHz clock
  input  wire       NRST_I,        // Power-on reset, active low
  input  wire       EXT_NRST_I,    // External reset pin, active low
  input  wire [7:0] REG_ADDR_I,    // Register address
  input  wire [7:0] REG_WDATA_I,   // Write data
  input  wire       REG_WR_I,      // Write strobe
  input  wire       REG_RD_I,      // Read strobe
  output reg  [7:0] REG_RDATA_O,   // Read data, one cycle later
  output reg  [7:0] IO_O,          // IO pin levels
  output reg  [7:0] HIGH_INPUT_O   // High input mode per IO
);

  localparam [3:0] ST_ON   = 4'b0001;
  localparam [3:0] ST_FALL = 4'b0010;
  localparam [3:0] ST_OFF  = 4'b0100;
  localparam [3:0] ST_RISE = 4'b1000;

  reg [7:0] data_reg;
  reg [7:0] misc_reg;
  reg [7:0] leden_reg;
  reg [4:0] ton_reg  [0:7];
  reg [7:0] onl_reg  [0:7];
  reg [7:0] off_reg  [0:7];
  reg [4:0] fin_reg  [0:7];
  reg [4:0] fout_reg [0:7];
  reg       key_arm_reg;
  reg       swrst_reg;
  reg [7:0] rdata_next;
  integer   k;

  wire [7:0] pwm_cnt_w;
  wire       frame_w;
  wire [7:0] pin_w;
  wire [6:0] wdec_w;
  wire [6:0] rdec_w;
  wire       full_rst_w;
  wire       cnt_rst_w;

  function [6:0] ch_decode;
    input [7:0] a;
    reg   [7:0] d;
    reg   [7:0] c;
    reg   [7:0] s;
    begin
      d = a - `FSF_ADDR_CH_BASE;
      c = d / `FSF_CH_STRIDE;
      s = d % `FSF_CH_STRIDE;
      ch_decode = {(a >= `FSF_ADDR_CH_BASE) && (d < `FSF_CH_SPAN),
                   c[2:0], s[2:0]};
    end
  endfunction

  function [13:0] per_len;
    input [4:0] t;
    begin
      if (t < `FSF_TIME_HI)
        per_len = {3'h0, t, 6'h00};
      else
        per_len = {t, 9'h000};
    end
  endfunction

  function [8:0] fade_len;
    input [4:0] t;
    begin
      if (t < `FSF_TIME_HI)
        fade_len = {4'h0, t};
      else
        fade_len = {t, 4'h0};
    end
  endfunction

  assign wdec_w = ch_decode(REG_ADDR_I);
  assign rdec_w = ch_decode(REG_ADDR_I);

  assign full_rst_w = swrst_reg |
                      (~EXT_NRST_I & ~misc_reg[`FSF_MISC_XRST]);
  assign cnt_rst_w  = full_rst_w | ~EXT_NRST_I;

  // Register file
  always @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      data_reg     <= `FSF_RST_DATA;
      misc_reg     <= `FSF_RST_ZERO;
      leden_reg    <= `FSF_RST_ZERO;
      HIGH_INPUT_O <= `FSF_RST_ZERO;
      for (k = 0; k < 8; k = k + 1) begin
        ton_reg[k]  <= 5'h00;
        onl_reg[k]  <= `FSF_RST_ONL;
        off_reg[k]  <= `FSF_RST_ZERO;
        fin_reg[k]  <= 5'h00;
        fout_reg[k] <= 5'h00;
      end
    end else if (full_rst_w) begin
      data_reg     <= `FSF_RST_DATA;
      // External-reset-mode bit 2 survives external reset; power-on and key reset clear it
      misc_reg     <= swrst_reg ? `FSF_RST_ZERO :
                      (misc_reg & 8'h04);
      leden_reg    <= `FSF_RST_ZERO;
      HIGH_INPUT_O <= `FSF_RST_ZERO;
      for (k = 0; k < 8; k = k + 1) begin
        ton_reg[k]  <= 5'h00;
        onl_reg[k]  <= `FSF_RST_ONL;
        off_reg[k]  <= `FSF_RST_ZERO;
        fin_reg[k]  <= 5'h00;
        fout_reg[k] <= 5'h00;
      end
    end else if (REG_WR_I) begin
      case (REG_ADDR_I)
        `FSF_ADDR_DATA:   data_reg <= REG_WDATA_I;
        `FSF_ADDR_MISC:   misc_reg <= REG_WDATA_I;
        `FSF_ADDR_LEDEN:  leden_reg <= REG_WDATA_I;
        `FSF_ADDR_HIGHIN: HIGH_INPUT_O <= REG_WDATA_I;
        default: begin
          if (wdec_w[6]) begin
            case (wdec_w[2:0])
              `FSF_SUB_TON:  ton_reg[wdec_w[5:3]]  <= REG_WDATA_I[4:0];
              `FSF_SUB_ONL:  onl_reg[wdec_w[5:3]]  <= REG_WDATA_I;
              `FSF_SUB_OFF:  off_reg[wdec_w[5:3]]  <= REG_WDATA_I;
              `FSF_SUB_FIN:  fin_reg[wdec_w[5:3]]  <= REG_WDATA_I[4:0];
              `FSF_SUB_FOUT: fout_reg[wdec_w[5:3]] <= REG_WDATA_I[4:0];
              default:       data_reg <= data_reg;
            endcase
          end
        end
      endcase
    end
  end

  always @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      key_arm_reg <= 1'b0;
      swrst_reg   <= 1'b0;
    end else begin
      swrst_reg <= 1'b0;
      if (swrst_reg) begin
        key_arm_reg <= 1'b0;
      end else if (REG_WR_I) begin
        // Any other write in between breaks the sequence
        key_arm_reg <= (REG_ADDR_I == `FSF_ADDR_SWRST) &&
                       (REG_WDATA_I == `FSF_KEY1);
        swrst_reg   <= key_arm_reg &&
                       (REG_ADDR_I == `FSF_ADDR_SWRST) &&
                       (REG_WDATA_I == `FSF_KEY2);
      end
    end
  end

  always @* begin
    rdata_next = REG_RDATA_O;
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        `FSF_ADDR_DATA:   rdata_next = data_reg;
        `FSF_ADDR_MISC:   rdata_next = misc_reg;
        `FSF_ADDR_LEDEN:  rdata_next = leden_reg;
        `FSF_ADDR_HIGHIN: rdata_next = HIGH_INPUT_O;
        `FSF_ADDR_SWRST:  rdata_next = `FSF_RST_ZERO;
        default: begin
          rdata_next = `FSF_RST_ZERO;
          if (rdec_w[6]) begin
            case (rdec_w[2:0])
              `FSF_SUB_TON:
                rdata_next = {3'h0, ton_reg[rdec_w[5:3]]};
              `FSF_SUB_ONL:
                rdata_next = onl_reg[rdec_w[5:3]];
              `FSF_SUB_OFF:
                rdata_next = off_reg[rdec_w[5:3]];
              `FSF_SUB_FIN:
                rdata_next = {3'h0, fin_reg[rdec_w[5:3]]};
              `FSF_SUB_FOUT:
                rdata_next = {3'h0, fout_reg[rdec_w[5:3]]};
              default:
                rdata_next = `FSF_RST_ZERO;
            endcase
          end
        end
      endcase
    end
  end

  always @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      REG_RDATA_O <= `FSF_RST_ZERO;
      IO_O        <= `FSF_RST_DATA;
    end else begin
      REG_RDATA_O <= rdata_next;
      IO_O        <= pin_w;
    end
  end

  fsf_tick_gen u_tick (
    .clk_i     (MCLK_I),
    .nrst_i    (NRST_I),
    .clr_i     (cnt_rst_w),
    .pwm_cnt_o (pwm_cnt_w),
    .frame_o   (frame_w)
  );

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_ch
      reg  [3:0]  st_reg;
      reg  [13:0] cnt_reg;
      reg  [8:0]  stp_reg;
      reg  [7:0]  lvl_reg;
      reg         shot_reg;
      wire        cap_w   = |(`FSF_FADE_MASK & (8'h01 << i));
      wire [7:0]  offl_w  = {3'h0, off_reg[i][2:0], 2'h0};
      wire [7:0]  onl_w   = onl_reg[i];
      wire [4:0]  toff_w  = off_reg[i][7:3];
      wire [4:0]  fin_w   = cap_w ? fin_reg[i] : 5'h00;
      wire [4:0]  fout_w  = cap_w ? fout_reg[i] : 5'h00;
      // only enabled IOs blink or fade
      wire        req_w   = ~data_reg[i] & leden_reg[i];
      wire        on_done = (ton_reg[i] != 5'h00) &&
                    (cnt_reg >= per_len(ton_reg[i]) - 14'h0001);
      wire        off_done = (cnt_reg >=
                    per_len(toff_w) - 14'h0001);
      wire        in_step = (stp_reg >= fade_len(fin_w) - 9'h001);
      wire        out_step = (stp_reg >= fade_len(fout_w) - 9'h001);

      always @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
          st_reg   <= ST_OFF;
          cnt_reg  <= 14'h0000;
          stp_reg  <= 9'h000;
          lvl_reg  <= 8'h00;
          shot_reg <= 1'b0;
        end else if (cnt_rst_w) begin
          st_reg   <= ST_OFF;
          cnt_reg  <= 14'h0000;
          stp_reg  <= 9'h000;
          lvl_reg  <= 8'h00;
          shot_reg <= 1'b0;
        end else if (frame_w) begin
          case (st_reg)
            ST_ON: begin
              lvl_reg <= onl_w;
              if (!req_w) begin
                st_reg  <= ST_FALL;
                stp_reg <= 9'h000;
              end else if (on_done) begin
                shot_reg <= (toff_w == 5'h00);
                st_reg   <= ST_FALL;
                stp_reg  <= 9'h000;
              end else begin
                cnt_reg <= cnt_reg + 14'h0001;
              end
            end
            ST_FALL: begin
              if (fout_w == 5'h00 || lvl_reg <= offl_w) begin
                st_reg  <= ST_OFF;
                lvl_reg <= offl_w;
                cnt_reg <= 14'h0000;
              end else if (out_step) begin
                lvl_reg <= lvl_reg - 8'h01;
                stp_reg <= 9'h000;
              end else begin
                stp_reg <= stp_reg + 9'h001;
              end
            end
            ST_OFF: begin
              lvl_reg <= offl_w;
              if (!req_w)
                shot_reg <= 1'b0;
              if (req_w && !shot_reg && (toff_w == 5'h00 ||
                  ton_reg[i] == 5'h00 || off_done)) begin
                st_reg  <= ST_RISE;
                stp_reg <= 9'h000;
              end else begin
                cnt_reg <= cnt_reg + 14'h0001;
              end
            end
            ST_RISE: begin
              if (!req_w) begin
                st_reg  <= ST_FALL;
                stp_reg <= 9'h000;
              end else if (fin_w == 5'h00 || lvl_reg >= onl_w) begin
                st_reg  <= ST_ON;
                lvl_reg <= onl_w;
                cnt_reg <= 14'h0000;
              end else if (in_step) begin
                lvl_reg <= lvl_reg + 8'h01;
                stp_reg <= 9'h000;
              end else begin
                stp_reg <= stp_reg + 9'h001;
              end
            end
            default: begin
              st_reg <= ST_OFF;
            end
          endcase
        end
      end

      fsf_pwm_cmp u_cmp (
        .level_i   (lvl_reg),
        .pwm_cnt_i (pwm_cnt_w),
        .log_i     (misc_reg[`FSF_MISC_LOG]),
        .fade_i    (cap_w),
        .en_i      (leden_reg[i]),
        .data_i    (data_reg[i]),
        .pin_o     (pin_w[i])
      );
    end
  endgenerate

endmodule

// *** rtl/fsf_pwm_cmp.v ***
`timescale 1ns/1ns

module fsf_pwm_cmp (
  input  wire [7:0] level_i,   // Pre-mapping level
  input  wire [7:0] pwm_cnt_i, // Shared PWM phase
  input  wire       log_i,     // Log mapping active
  input  wire       fade_i,    // IO is fading capable
  input  wire       en_i,      // LED driver enabled
  input  wire       data_i,    // IO data bit
  output wire       pin_o      // Next pin level
);

  // Square law: cheap and keeps 0 and 255 fixed
  function [7:0] log_map;
    input [7:0] x;
    reg   [15:0] sq;
    begin
      sq      = x * x + 16'h00FF;
      log_map = sq[15:8];
    end
  endfunction

  wire [7:0] lvl_w;
  wire       lit_w;

  assign lvl_w = (log_i && fade_i) ? log_map(level_i) : level_i;
  assign lit_w = (pwm_cnt_i < lvl_w);
  // Sinking LED: low pin lights it
  assign pin_o = en_i ? ~lit_w : data_i;

endmodule

// *** rtl/fsf_tick_gen.v ***
`timescale 1ns/1ns
`include "fsf_consts.vh"

module fsf_tick_gen (
  input  wire       clk_i,     // System clock
  input  wire       nrst_i,    // Async reset, active low
  input  wire       clr_i,     // Sync counter clear
  output reg  [7:0] pwm_cnt_o, // PWM phase 0..254
  output reg        frame_o    // Pulse at end of PWM period
);

  localparam [7:0] TICK_LAST = `FSF_TICK_LAST;

  reg [7:0] div_reg;

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_reg   <= 8'h00;
      pwm_cnt_o <= 8'h00;
      frame_o   <= 1'b0;
    end else if (clr_i) begin
      div_reg   <= 8'h00;
      pwm_cnt_o <= 8'h00;
      frame_o   <= 1'b0;
    end else begin
      frame_o <= 1'b0;
      if (div_reg == TICK_LAST) begin
        div_reg <= 8'h00;
        if (pwm_cnt_o == `FSF_PWM_LAST) begin
          pwm_cnt_o <= 8'h00;
          frame_o   <= 1'b1;
        end else begin
          pwm_cnt_o <= pwm_cnt_o + 8'h01;
        end
      end else begin
        div_reg <= div_reg + 8'h01;
      end
    end
  end

endmodule

// *** test/fsf_led_engine_chk.sv ***
`timescale 1ns/1ns

module fsf_led_engine_chk (
  input wire       MCLK_I,
  input wire       NRST_I,
  input wire       EXT_NRST_I,
  input wire [7:0] REG_ADDR_I,
  input wire [7:0] REG_WDATA_I,
  input wire       REG_WR_I,
  input wire       REG_RD_I,
  input wire [7:0] REG_RDATA_O,
  input wire [7:0] IO_O,
  input wire [7:0] HIGH_INPUT_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!NRST_I);

  key_reads_zero_a: assert property (
    REG_RD_I && REG_ADDR_I == 8'h7D |=> REG_RDATA_O == 8'h00)
    else $error("key register read not zero");
  high_in_write_a: assert property (
    REG_WR_I && REG_ADDR_I == 8'h2A |=> HIGH_INPUT_O == $past(REG_WDATA_I))
    else $error("high input bits not updated");
  high_in_read_a: assert property (
    REG_RD_I && REG_ADDR_I == 8'h2A |=> REG_RDATA_O == $past(HIGH_INPUT_O))
    else $error("high input readback differs");
  pins_after_reset_a: assert property (
    $rose(NRST_I) |-> IO_O == 8'hFF)
    else $error("pins not idle high after reset");
  fade_bits_zero_a: assert property (
    REG_RD_I && REG_ADDR_I >= 8'h30 && REG_ADDR_I <= 8'h57 &&
    (REG_ADDR_I - 8'h30) % 8'h05 >= 8'h03 |=> REG_RDATA_O[7:5] == 3'h0)
    else $error("fade register unused bits not zero");
  on_time_width_a: assert property (
    REG_RD_I && REG_ADDR_I >= 8'h30 && REG_ADDR_I <= 8'h57 &&
    (REG_ADDR_I - 8'h30) % 8'h05 == 8'h00 |=> REG_RDATA_O[7:5] == 3'h0)
    else $error("on time unused bits not zero");
  key_reset_a: assert property (
    REG_WR_I && REG_ADDR_I == 8'h7D && REG_WDATA_I == 8'h34 &&
    !$past(REG_WR_I) &&
    $past(REG_WR_I && REG_ADDR_I == 8'h7D && REG_WDATA_I == 8'h12, 2)
    |-> ##[2:4] HIGH_INPUT_O == 8'h00)
    else $error("key sequence gave no reset");
  rdata_hold_a: assert property (
    !REG_RD_I |=> $stable(REG_RDATA_O))
    else $error("read data changed without read");
endmodule

bind fsf_led_engine fsf_led_engine_chk u_chk (
  .MCLK_I(MCLK_I), .NRST_I(NRST_I), .EXT_NRST_I(EXT_NRST_I),
  .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
  .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
  .IO_O(IO_O), .HIGH_INPUT_O(HIGH_INPUT_O));

// *** test/fsf_led_model.sv ***
`timescale 1ns/1ns

// LEDs tied from supply to each pin, so a low pin lights its LED
module fsf_led_model (
  input  wire [7:0] pin_i, // Device pin levels
  output wire [7:0] lit_o  // LED lit per IO
);
  assign lit_o = ~pin_i;
endmodule

// *** test/tb_led_blink_fade_engine.sv ***
`timescale 1ns/1ns
`define FSF_CHK(nm, ex, got) begin \
  n_checks++; \
  if ((got) !== (ex)) begin \
    fail_count++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, got); \
  end \
end

module tb_led_blink_fade_engine;
  localparam int FRAME = 2550;
  localparam int LIMIT = 90000;
  logic       MCLK_I = 1'b0;
  logic       NRST_I = 1'b0;
  logic       EXT_NRST_I = 1'b1;
  logic [7:0] REG_ADDR_I = 8'h00;
  logic [7:0] REG_WDATA_I = 8'h00;
  logic       REG_WR_I = 1'b0;
  logic       REG_RD_I = 1'b0;
  wire  [7:0] REG_RDATA_O;
  wire  [7:0] IO_O;
  wire  [7:0] HIGH_INPUT_O;
  wire  [7:0] lit;
  int         n_checks = 0;
  int         fail_count = 0;
  int         cyc = 0;
  int         w = 0;
  int         lit_cnt [8];

  fsf_led_engine DUT (
    .MCLK_I(MCLK_I), .NRST_I(NRST_I), .EXT_NRST_I(EXT_NRST_I),
    .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
    .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
    .IO_O(IO_O), .HIGH_INPUT_O(HIGH_INPUT_O));
  fsf_led_model u_leds (.pin_i(IO_O), .lit_o(lit));

  always #25 MCLK_I = ~MCLK_I;

  task close_out;
    if (fail_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge MCLK_I) begin
    cyc++;
    if (cyc == LIMIT) begin
      fail_count++;
      close_out();
    end
  end

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge MCLK_I);
    REG_ADDR_I = a;
    REG_WDATA_I = d;
    REG_WR_I = 1'b1;
    @(negedge MCLK_I);
    REG_WR_I = 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] ex);
    @(negedge MCLK_I);
    REG_ADDR_I = a;
    REG_RD_I = 1'b1;
    @(negedge MCLK_I);
    REG_RD_I = 1'b0;
    `FSF_CHK($sformatf("reg_%0h", a), ex, REG_RDATA_O)
  endtask

  task ext_pulse;
    @(negedge MCLK_I);
    EXT_NRST_I = 1'b0;
    repeat (2) @(negedge MCLK_I);
    EXT_NRST_I = 1'b1;
    repeat (2) @(negedge MCLK_I);
  endtask

  // Settle three frames, then count lit cycles over one whole frame
  task measure;
    repeat (3 * FRAME) @(negedge MCLK_I);
    lit_cnt = '{default: 0};
    repeat (FRAME) begin
      @(negedge MCLK_I);
      for (int i = 0; i < 8; i++)
        lit_cnt[i] += lit[i];
    end
  endtask

  // Width of the next lit pulse of IO4, one pulse per PWM frame
  task pulse_w(output int wd);
    @(posedge lit[4]);
    wd = 0;
    @(negedge MCLK_I);
    while (lit[4]) begin
      wd++;
      @(negedge MCLK_I);
    end
  endtask

  initial begin
    repeat (16) @(negedge MCLK_I);
    NRST_I = 1'b1;
    `FSF_CHK("io_idle", 8'hFF, IO_O) // disabled pins idle
    rd(8'h30, 8'h00); // on time reset
    rd(8'h31, 8'hFF); // on level reset
    rd(8'h32, 8'h00); // off reset
    rd(8'h2A, 8'h00); // high input reset
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'h1F); // five bit field
    wr(8'h32, 8'hA5);
    rd(8'h32, 8'hA5); // off time and level
    wr(8'h33, 8'h1F);
    rd(8'h33, 8'h1F); // fade field stored
    wr(8'h47, 8'hFF);
    rd(8'h47, 8'h1F); // fade in field
    wr(8'h48, 8'h13);
    rd(8'h48, 8'h13); // fade out field
    wr(8'h2A, 8'h5A);
    rd(8'h2A, 8'h5A); // high input readback
    `FSF_CHK("high_in", 8'h5A, HIGH_INPUT_O) // high input pins
    wr(8'h7D, 8'h56);
    rd(8'h7D, 8'h00); // key reads zero
    wr(8'h31, 8'h80);
    // Interrupted key must not reset
    wr(8'h7D, 8'h12);
    wr(8'h2A, 8'h11);
    wr(8'h7D, 8'h34);
    repeat (4) @(negedge MCLK_I);
    rd(8'h2A, 8'h11); // broken key ignored
    wr(8'h7D, 8'h12);
    wr(8'h7D, 8'h34);
    repeat (4) @(negedge MCLK_I);
    rd(8'h2A, 8'h00); // key resets
    rd(8'h31, 8'hFF); // level back to reset
    rd(8'h47, 8'h00); // fade back to reset
    wr(8'h08, 8'h00);
    wr(8'h11, 8'h11);
    wr(8'h31, 8'h80);
    wr(8'h45, 8'h80);
    measure();
    `FSF_CHK("lit_io0", 1280, lit_cnt[0]) // linear level
    `FSF_CHK("lit_io4", 1280, lit_cnt[4]) // static mode on
    `FSF_CHK("lit_io1", FRAME, lit_cnt[1]) // disabled follows data
    wr(8'h10, 8'h08);
    measure();
    `FSF_CHK("log_io4", 640, lit_cnt[4]) // log mapping
    `FSF_CHK("log_io0", 1280, lit_cnt[0]) // plain IO stays linear
    // Plain IO0 gets a fade-out value that it must ignore
    wr(8'h34, 8'h01);
    wr(8'h32, 8'h07);
    wr(8'h46, 8'h07);
    wr(8'h08, 8'h11);
    measure();
    `FSF_CHK("off_io0", 280, lit_cnt[0]) // linear off level
    `FSF_CHK("off_io4", 40, lit_cnt[4]) // log off level
    wr(8'h10, 8'h0C);
    ext_pulse();
    `FSF_CHK("io_cnt_clr", 8'h11, IO_O) // counters cleared
    rd(8'h45, 8'h80); // counters only
    rd(8'h10, 8'h0C); // mode kept
    wr(8'h10, 8'h08);
    ext_pulse();
    `FSF_CHK("io_full_rst", 8'hFF, IO_O) // full reset pins
    rd(8'h45, 8'hFF); // full reset mode
    rd(8'h10, 8'h00); // linear after reset
    // Ramp IO4 from level 0 to 4 and back, one step per frame
    wr(8'h11, 8'h10);
    wr(8'h45, 8'h04);
    wr(8'h47, 8'h01);
    wr(8'h48, 8'h01);
    wr(8'h08, 8'hEF);
    pulse_w(w);
    pulse_w(w);
    `FSF_CHK("rise_w2", 20, w) // one step per frame
    pulse_w(w);
    `FSF_CHK("rise_w3", 30, w) // ramp up
    pulse_w(w);
    `FSF_CHK("rise_w4", 40, w) // ramp reaches on level
    wr(8'h08, 8'hFF);
    pulse_w(w);
    pulse_w(w);
    `FSF_CHK("fall_w2", 30, w) // ramp down
    pulse_w(w);
    `FSF_CHK("fall_w3", 20, w) // one step per frame
    close_out();
  end
endmodule
